// [include/iske_pkg.sv]
package iske_pkg;
  // operand field layout
  localparam int OP_D_BIT   = 9;
  localparam int OP_A_BIT   = 8;
  localparam logic [7:0] IDX_LIMIT = 8'h5F;
  // flag positions in the status byte
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] ACC_RST   = 8'h00;
  // opcode prefixes
  localparam logic [5:0] OPC_INC_SKIP_ZERO = 6'h0F;
  localparam logic [5:0] OPC_INC_SKIP_NZ   = 6'h12;
  localparam logic [5:0] OPC_INC_FILE      = 6'h0A;
  localparam logic [5:0] OPC_OR_FILE       = 6'h04;
  localparam logic [7:0] OPC_OR_LIT        = 8'h09;
  localparam logic [9:0] OPC_LOAD_PTR      = 10'h3B8;
  localparam logic [5:0] OPC_LOAD_PTR_W2   = 6'h3C;
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_BANK   = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;
  localparam int CTRL_EXT_BIT = 0;
  localparam logic [5:0] BANK_RST = 6'h00;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    ISKE_EXEC = 2'b00,
    ISKE_PTR2 = 2'b01,
    ISKE_SKIP = 2'b10
  } iske_state_t;
  typedef struct packed {
    logic [13:0] addr;
    logic        we;
    logic [7:0]  wdata;
  } iske_fmem_t;
endpackage

// [rtl/iske_exec.sv]
// Notes on behaviour
// (RL1) inc-skip-zero: zero result discards prefetched word, runs nop instead.
// (RL2) inc-skip-nonzero writes result; nonzero result discards the next word.
// (RL3) skipping one-word instruction adds one nop cycle, two cycles total.
// (RL4) skipping a two-word instruction gives three cycles, two nops.
// (RL5) skipping a three-word instruction gives four cycles total.
// (RL6) no skip: increment-skip is one word, one cycle.
// (RL7) d=0 result to accumulator; d=1 result back to file register.
// (RL8) a=0 selects access bank; a=1 uses bank select register.
// (RL9) a=0, extended set on, f<=95: indexed literal offset addressing.
// (RL10) inc-skip-nonzero decoded from 010010da ffffffff; flags unchanged.
// (RL11) or-literal 00001001 k: acc |= k in one cycle, sets N and Z.
// (RL12) or-with-file 000100da: acc | file, routed by d, sets N and Z.
// (RL13) load-pointer 1110111000ff: literal to chosen pointer, flags kept.
// (RL14) flush pulses toward fetch once per discarded instruction word.
// (RL15) plain increment sets C, DC, N, OV, Z; skipping variants do not.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the address map.
module iske_exec
  import iske_pkg::*;
#(
  parameter logic [5:0] ACCESS_HI_BANK = 6'h3F
) (
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic              s_awvalid,
  output      logic              s_awready,
  input  wire logic [3:0]        s_awaddr,
  input  wire logic              s_wvalid,
  output      logic              s_wready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  output      logic              s_bvalid,
  input  wire logic              s_bready,
  output      logic [1:0]        s_bresp,
  input  wire logic              s_arvalid,
  output      logic              s_arready,
  input  wire logic [3:0]        s_araddr,
  output      logic              s_rvalid,
  input  wire logic              s_rready,
  output      logic [31:0]       s_rdata,
  output      logic [1:0]        s_rresp,
  // instruction stream from fetch
  input  wire logic              instr_valid,
  input  wire logic [15:0]       instr_word,
  input  wire logic [1:0]        next_words,
  output      logic              flush,
  // data memory
  output      iske_fmem_t        file_req,
  input  wire logic [7:0]        file_rdata,
  // core state
  output      logic [7:0]        acc_out,
  output      logic [7:0]        flags_out,
  output      logic [2:0][13:0]  pointer_regs
);

  function automatic logic is_file_op(input logic [15:0] w);
    is_file_op = (w[15:10] == OPC_INC_SKIP_ZERO) ||
                 (w[15:10] == OPC_INC_SKIP_NZ) ||
                 (w[15:10] == OPC_INC_FILE) ||
                 (w[15:10] == OPC_OR_FILE);
  endfunction

  iske_state_t      state_reg, state_next;
  logic [1:0]       skip_cnt_reg, skip_cnt_next;
  logic [7:0]       acc_reg, flags_reg;
  logic [5:0]       bank_select_reg;
  logic             ext_en_reg;
  logic [2:0][13:0] ptr_reg;
  logic [1:0]       ptr_sel_reg;
  logic [3:0]       ptr_hi_reg;

  // decode
  wire       exec_fire = (state_reg == ISKE_EXEC) && instr_valid;
  wire [7:0] f_field   = instr_word[7:0];
  wire       d_bit     = instr_word[OP_D_BIT];
  wire       a_bit     = instr_word[OP_A_BIT];
  wire       op_isz    = instr_word[15:10] == OPC_INC_SKIP_ZERO;
  wire       op_isnz   = instr_word[15:10] == OPC_INC_SKIP_NZ; // RL10
  wire       op_inc    = instr_word[15:10] == OPC_INC_FILE;
  wire       op_orf    = instr_word[15:10] == OPC_OR_FILE;
  wire       op_orl    = instr_word[15:8] == OPC_OR_LIT;
  wire       op_ldp    = instr_word[15:6] == OPC_LOAD_PTR;
  wire       file_op   = is_file_op(instr_word);

  // addressing
  wire        idx_mode  = !a_bit && ext_en_reg && f_field <= IDX_LIMIT; // RL9
  wire [13:0] idx_addr  = ptr_reg[2] + {6'h00, f_field};
  wire [5:0]  acc_bank  = (f_field <= IDX_LIMIT) ? 6'h00 : ACCESS_HI_BANK;
  wire [5:0]  bank_used = a_bit ? bank_select_reg : acc_bank; // RL8
  wire [13:0] eff_addr  = idx_mode ? idx_addr : {bank_used, f_field};

  // alu
  wire [8:0] inc_sum  = {1'b0, file_rdata} + 9'h001;
  wire [7:0] inc_res  = inc_sum[7:0];
  wire [7:0] orf_res  = acc_reg | file_rdata; // RL12
  wire [7:0] orl_res  = acc_reg | f_field; // RL11
  wire       inc_zero = inc_res == 8'h00;
  wire [7:0] file_res = op_orf ? orf_res : inc_res;
  wire       do_skip  = exec_fire && ((op_isz && inc_zero) || // RL1
                                      (op_isnz && !inc_zero)); // RL2
  // a zero word count still occupies one slot
  wire [1:0] skip_len = (next_words == 2'd0) ? 2'd1 : next_words;

  // flag update, skipping increments keep flags
  logic [7:0] flags_calc;
  always_comb begin
    flags_calc = flags_reg;
    if (op_inc) begin // RL15
      flags_calc[FLAG_C]  = inc_sum[8];
      flags_calc[FLAG_DC] = file_rdata[3:0] == 4'hF;
      flags_calc[FLAG_OV] = file_rdata == 8'h7F;
      flags_calc[FLAG_N]  = inc_res[7];
      flags_calc[FLAG_Z]  = inc_zero;
    end else if (op_orf || op_orl) begin // RL11 RL12
      flags_calc[FLAG_N]  = file_res[7] & op_orf | orl_res[7] & op_orl;
      flags_calc[FLAG_Z]  = op_orf ? (orf_res == 8'h00) : (orl_res == 8'h00);
    end
  end

  assign file_req.addr  = eff_addr;
  assign file_req.we    = exec_fire && file_op && d_bit; // RL7
  assign file_req.wdata = file_res;

  always_comb begin
    state_next    = state_reg;
    skip_cnt_next = skip_cnt_reg;
    case (state_reg)
      ISKE_EXEC: begin
        if (do_skip) begin // RL3 RL4 RL5 RL6
          state_next    = ISKE_SKIP;
          skip_cnt_next = skip_len;
        end else if (exec_fire && op_ldp) begin
          state_next = ISKE_PTR2;
        end
      end
      ISKE_PTR2: begin
        if (instr_valid) begin
          state_next = ISKE_EXEC;
        end
      end
      ISKE_SKIP: begin
        skip_cnt_next = skip_cnt_reg - 2'd1;
        if (skip_cnt_reg == 2'd1) begin
          state_next = ISKE_EXEC;
        end
      end
      default: begin
        state_next = ISKE_EXEC;
      end
    endcase
  end

  // every skipped word costs one nop cycle; fetch drops that word
  assign flush = state_reg == ISKE_SKIP; // RL14

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ISKE_EXEC;
      skip_cnt_reg <= 2'd0;
    end else begin
      state_reg    <= state_next;
      skip_cnt_reg <= skip_cnt_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_reg   <= ACC_RST;
      flags_reg <= FLAGS_RST;
    end else if (exec_fire) begin
      flags_reg <= flags_calc; // RL10
      if (op_orl) begin
        acc_reg <= orl_res; // RL11
      end else if (file_op && !d_bit) begin
        acc_reg <= file_res; // RL7
      end
    end
  end

  // load pointer: first word holds selector and high literal bits
  wire ldp_w2 = (state_reg == ISKE_PTR2) && instr_valid &&
                (instr_word[15:10] == OPC_LOAD_PTR_W2);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_sel_reg <= 2'd0;
      ptr_hi_reg  <= 4'h0;
    end else if (exec_fire && op_ldp) begin
      ptr_sel_reg <= instr_word[5:4];
      ptr_hi_reg  <= instr_word[3:0];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ptr_reg[gi] <= 14'h0000;
        end else if (ldp_w2 && (ptr_sel_reg == 2'(gi))) begin
          ptr_reg[gi] <= {ptr_hi_reg, instr_word[9:0]}; // RL13
        end
      end
    end
  endgenerate

  assign acc_out      = acc_reg;
  assign flags_out    = flags_reg;
  assign pointer_regs = ptr_reg;

  // axi4-lite: address and data latched independently
  logic       aw_held_reg, w_held_reg;
  logic [3:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  wire        wr_go    = aw_held_reg && w_held_reg && !s_bvalid;
  wire        wr_ctrl  = wr_go && (aw_addr_reg == ADDR_CTRL) && w_strb_reg[0];
  wire        wr_bank  = wr_go && (aw_addr_reg == ADDR_BANK) && w_strb_reg[0];
  wire        wr_known = (aw_addr_reg == ADDR_CTRL) ||
                         (aw_addr_reg == ADDR_BANK) ||
                         (aw_addr_reg == ADDR_STATUS);
  wire        rd_known = (s_araddr == ADDR_CTRL) || (s_araddr == ADDR_BANK) ||
                         (s_araddr == ADDR_STATUS);
  wire [31:0] rd_mux   = (s_araddr == ADDR_CTRL) ? {31'h0, ext_en_reg} :
                         (s_araddr == ADDR_BANK) ? {26'h0, bank_select_reg} :
                         (s_araddr == ADDR_STATUS) ?
                           {14'h0, state_reg, flags_reg, acc_reg} : 32'h0;

  assign s_awready = !aw_held_reg;
  assign s_wready  = !w_held_reg;
  assign s_arready = !s_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_data_reg  <= 32'h0000_0000;
      w_strb_reg  <= 4'h0;
      s_bvalid    <= 1'b0;
      s_bresp     <= AXI_OKAY;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_wdata;
        w_strb_reg <= s_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        s_bvalid    <= 1'b1;
        s_bresp     <= wr_known ? AXI_OKAY : AXI_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_en_reg      <= 1'b0;
      bank_select_reg <= BANK_RST;
    end else begin
      if (wr_ctrl) begin
        ext_en_reg <= w_data_reg[CTRL_EXT_BIT];
      end
      if (wr_bank) begin
        bank_select_reg <= w_data_reg[5:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h0000_0000;
      s_rresp  <= AXI_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata  <= rd_mux;
      s_rresp  <= rd_known ? AXI_OKAY : AXI_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
    end
  end

  // checks
  wire isz_hit  = exec_fire && op_isz && inc_zero;
  wire isnz_hit = exec_fire && op_isnz && !inc_zero;

  chk_skip_one: assert property (@(posedge aclk) disable iff (!aresetn) // RL3
    (isz_hit || isnz_hit) && skip_len == 2'd1 |=> flush ##1 !flush)
    else $error("one-word skip not one nop");
  chk_skip_two: assert property (@(posedge aclk) disable iff (!aresetn) // RL4
    (isz_hit || isnz_hit) && skip_len == 2'd2 |=> flush [*2] ##1 !flush)
    else $error("two-word skip not two nops");
  chk_skip_three: assert property ( // RL5
    @(posedge aclk) disable iff (!aresetn)
    (isz_hit || isnz_hit) && skip_len == 2'd3 |=> flush [*3] ##1 !flush)
    else $error("three-word skip not three nops");
  chk_no_skip: assert property (@(posedge aclk) disable iff (!aresetn) // RL6
    exec_fire && (op_isz && !inc_zero || op_isnz && inc_zero) |=> !flush)
    else $error("skip taken without cause");
  chk_nz_write: assert property (@(posedge aclk) disable iff (!aresetn) // RL2
    exec_fire && op_isnz && d_bit |-> file_req.we && file_req.wdata == inc_res)
    else $error("nonzero skip lost its write");
  chk_dest_acc: assert property (@(posedge aclk) disable iff (!aresetn) // RL7
    exec_fire && file_op && !d_bit
    |-> !file_req.we ##1 acc_reg == $past(file_res))
    else $error("d=0 result not in accumulator");
  chk_bank_sel: assert property (@(posedge aclk) disable iff (!aresetn) // RL8
    exec_fire && file_op && a_bit |-> file_req.addr[13:8] == bank_select_reg)
    else $error("bank select not used");
  chk_index_mode: assert property ( // RL9
    @(posedge aclk) disable iff (!aresetn)
    exec_fire && file_op && !a_bit && ext_en_reg && f_field <= IDX_LIMIT
    |-> file_req.addr == idx_addr)
    else $error("indexed offset not applied");
  chk_flags_keep: assert property ( // RL10
    @(posedge aclk) disable iff (!aresetn)
    exec_fire && (op_isnz || op_isz || op_ldp) |=> $stable(flags_reg))
    else $error("skip increment touched flags");
  chk_or_lit: assert property (@(posedge aclk) disable iff (!aresetn) // RL11
    exec_fire && op_orl |=> acc_reg == ($past(acc_reg) | $past(f_field)))
    else $error("or literal wrong");
  chk_load_ptr: assert property (@(posedge aclk) disable iff (!aresetn) // RL13
    ldp_w2 && ptr_sel_reg == 2'd1
    |=> ptr_reg[1][9:0] == $past(instr_word[9:0]))
    else $error("pointer not loaded");

  cov_skip_zero: cover property (@(posedge aclk) disable iff (!aresetn)
    isz_hit ##1 flush);
  cov_skip_nz3: cover property (@(posedge aclk) disable iff (!aresetn)
    isnz_hit && skip_len == 2'd3);
  cov_load_ptr: cover property (@(posedge aclk) disable iff (!aresetn)
    exec_fire && op_ldp ##1 ldp_w2);

endmodule // iske_exec

// [tb/iske_mem.sv]
module iske_mem
  import iske_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // data memory port
  input  wire iske_fmem_t file_req,
  output      logic [7:0] file_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // unwritten bytes read unknown, so a stray read shows up
  logic [7:0] mem [16384];
  assign file_rdata = mem[file_req.addr];
  always @(posedge aclk) begin
    if (file_req.we === 1'h1) begin
      mem[file_req.addr] <= file_req.wdata;
    end
  end
endmodule // iske_mem

// [tb/tb.sv]
module tb
  import iske_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // not the design default, so the high access bank is really routed
  localparam logic [5:0] HI = 6'h2A;
  logic             aclk = 1'h0;
  logic             aresetn, s_awvalid, s_wvalid, s_bready, ext;
  logic             s_arvalid, s_rready, instr_valid, flush;
  logic             s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [3:0]       s_awaddr, s_araddr, s_wstrb;
  logic [31:0]      s_wdata, s_rdata;
  logic [1:0]       s_bresp, s_rresp, next_words;
  logic [15:0]      instr_word;
  iske_fmem_t       file_req;
  logic [7:0]       file_rdata, acc_out, flags_out, accm, flg;
  logic [2:0][13:0] pointer_regs;
  logic [13:0]      ptr [3];
  logic [5:0]       bank;
  logic [31:0]      wq [$], fq [$];
  int               failures = 0, checked = 0, fl_cnt = 0;

  iske_exec #(.ACCESS_HI_BANK(HI)) iske_exec_i (
    .aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
    .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp,
    .s_arvalid, .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata,
    .s_rresp, .instr_valid, .instr_word, .next_words, .flush, .file_req,
    .file_rdata, .acc_out, .flags_out, .pointer_regs
  );
  iske_mem iske_mem_i (.aclk, .file_req, .file_rdata);

  always #25 aclk = ~aclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic axw(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'h1;
    s_wvalid <= 1'h1;
    fork
      begin
        do @(posedge aclk); while (s_awready !== 1'h1);
        s_awvalid <= 1'h0;
      end
      begin
        do @(posedge aclk); while (s_wready !== 1'h1);
        s_wvalid <= 1'h0;
      end
    join
    s_bready <= 1'h1;
    do @(posedge aclk); while (s_bvalid !== 1'h1);
    s_bready <= 1'h0;
    chk(s_bresp, r);
  endtask

  task automatic axr(input logic [3:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    do @(posedge aclk); while (s_arready !== 1'h1);
    s_arvalid <= 1'h0;
    s_rready <= 1'h1;
    do @(posedge aclk); while (s_rvalid !== 1'h1);
    s_rready <= 1'h0;
    chk(s_rdata, d);
    chk(s_rresp, r);
  endtask

  task automatic op(input logic [15:0] w, input int sk);
    instr_valid <= 1'h1;
    instr_word <= w;
    next_words <= 2'(sk > 0 ? sk : $urandom_range(3, 1));
    if (sk > 0) fq.push_back(sk);
    @(posedge aclk);
    // fetch keeps offering words during a skip; all must be dropped
    repeat (sk) begin
      instr_word <= 16'($urandom);
      @(posedge aclk);
    end
  endtask

  // idle one edge, then read the state settled by the executing edge
  task automatic core();
    instr_valid <= 1'h0;
    instr_word <= 16'h0000;
    @(posedge aclk);
    chk(acc_out, accm);
    chk(flags_out, flg);
    for (int i = 0; i < 3; i++) chk(pointer_regs[i], ptr[i]);
  endtask

  function automatic logic [13:0] ea(input logic a, input logic [7:0] f);
    if (a) return {bank, f};
    if (f > 8'h5F) return {HI, f};
    return ext ? ptr[2] + 14'(f) : {6'h00, f};
  endfunction

  task automatic orl(input logic [7:0] k);
    accm = accm | k;
    flg[FLAG_N] = accm[7];
    flg[FLAG_Z] = (accm == 8'h00);
    op({8'h09, k}, 0);
    core();
  endtask

  task automatic bop(input logic [5:0] o, input logic d, input logic a,
                     input logic [7:0] f, input logic [7:0] v, input int nw);
    logic [13:0] ad;
    logic [7:0]  r;
    int          sk;
    ad = ea(a, f);
    iske_mem_i.mem[ad] = v;
    r = (o == 6'h04) ? (accm | v) : v + 8'h01;
    sk = 0;
    if (o == 6'h0F && r == 8'h00) sk = nw;
    if (o == 6'h12 && r != 8'h00) sk = nw;
    if (o == 6'h04 || o == 6'h0A) begin
      flg[FLAG_N] = r[7];
      flg[FLAG_Z] = (r == 8'h00);
    end
    if (o == 6'h0A) begin
      flg[FLAG_C] = (v == 8'hFF);
      flg[FLAG_DC] = (v[3:0] == 4'hF);
      flg[FLAG_OV] = (v == 8'h7F);
    end
    if (d) wq.push_back(32'({ad, r}));
    else accm = r;
    op({o, d, a, f}, sk);
    core();
  endtask

  task automatic lp(input logic [1:0] s, input logic [13:0] k);
    op({10'h3B8, s, k[13:10]}, 0);
    op({6'h3C, k[9:0]}, 0);
    if (s != 2'h3) ptr[s] = k;
    core();
  endtask

  // a flush run is closed by the first edge without flush
  always @(posedge aclk) begin
    if (flush === 1'h1) fl_cnt++;
    else if (fl_cnt > 0) begin
      chk(fl_cnt, fq.pop_front());
      fl_cnt = 0;
    end
    if (file_req.we === 1'h1) begin
      chk({file_req.addr, file_req.wdata}, wq.pop_front());
    end
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  initial begin
    {aresetn, s_awvalid, s_wvalid, s_bready, ext} = 5'h00;
    {s_arvalid, s_rready, instr_valid} = 3'h0;
    {s_awaddr, s_araddr, s_wstrb, s_wdata, next_words, instr_word} = 62'h0;
    {accm, flg, bank} = 22'h0;
    ptr = '{3{14'h0000}};
    void'($urandom(45855));
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    axr(ADDR_CTRL, 32'h0, AXI_OKAY);
    axr(ADDR_BANK, 32'h0, AXI_OKAY);
    axw(4'hC, 32'h1, AXI_SLVERR);
    axr(4'hC, 32'h0, AXI_SLVERR);
    bank = 6'h05;
    axw(ADDR_BANK, 32'(bank), AXI_OKAY);
    axr(ADDR_BANK, 32'(bank), AXI_OKAY);
    orl(8'h00);
    orl(8'($urandom));
    orl(8'h80);
    bop(6'h04, 1'h0, 1'h1, 8'($urandom), 8'($urandom), 1);
    bop(6'h04, 1'h1, 1'h0, 8'h10, 8'h3C, 1);
    bop(6'h04, 1'h1, 1'h0, 8'h60, 8'h01, 1);
    for (int n = 1; n < 4; n++) bop(6'h0F, 1'h1, 1'h1, 8'(n), 8'hFF, n);
    bop(6'h0F, 1'h0, 1'h1, 8'h20, 8'h41, 2);
    bop(6'h12, 1'h1, 1'h1, 8'h21, 8'hFF, 3);
    for (int n = 1; n < 4; n++) begin
      bop(6'h12, 1'h0, 1'h1, 8'h22, 8'($urandom_range(254, 0)), n);
    end
    bop(6'h0A, 1'h0, 1'h1, 8'h30, 8'h7F, 1);
    bop(6'h0A, 1'h1, 1'h1, 8'h31, 8'hFF, 1);
    for (int s = 0; s < 4; s++) lp(2'(s), 14'($urandom));
    axw(ADDR_CTRL, 32'h1, AXI_OKAY);
    ext = 1'h1;
    bop(6'h04, 1'h1, 1'h0, 8'h5F, 8'h5A, 1);
    bop(6'h0A, 1'h1, 1'h0, 8'h60, 8'h11, 1);
    axr(ADDR_STATUS, {14'h0, 2'h0, flg, accm}, AXI_OKAY);
    repeat (3) @(posedge aclk);
    chk(wq.size() + fq.size(), 32'h0);
    finish_test();
  end
endmodule // tb
